/* core/microprogram_sequencer.sv */
// microprogrammed control sequencer of a 16-bit cpu
// Function
// RULE_01: after reset the program counter is zero and the first fetch uses it.
// RULE_02: each fetched instruction is decoded and dispatched to its microcode sequence.
// RULE_03: the pipeline register takes each microinstruction of the sequence in turn.
// RULE_04: at instruction end fetch next unless prefetched, then decode, repeat forever.
// RULE_05: source and destination fields predecode to 3-bit mode codes before loading.
// RULE_06: mode codes run absolute 000 up to indexed 110; 111 means illegal.
// RULE_07: two mode codes plus four opcode bits index both dispatch tables.
// RULE_08: first dispatch table gives fetch or operandless start, used unlatched.
// RULE_09: execute start address is held in an 8-bit enabled register.
// RULE_10: next address comes from exactly one of four enabled sources.
// RULE_11: source select uses condition field, loop count, interrupt bits; four enables.
// RULE_12: conditions are unconditional, loop zero, interrupt pending, interrupts enabled.
// RULE_13: eight registered 512x8 stores plus one unregistered next-address store.
// RULE_14: loop counter loads first register number and steps for multi-register moves.
// RULE_15: interrupt branch only when pending and enabled, else normal source.
`timescale 1ns/10ps
`default_nettype none
`include "useq_params.svh"

module microprogram_sequencer
#(
    parameter int UADDR_W = 9,
    parameter int STORE_DEPTH = 512,
    parameter int MW_BYTES = 8,
    parameter int DISP_DEPTH = 1024
)
(
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET,
    // instruction fetch
    output logic FETCH_REQ,
    output logic [15:0] PROGRAM_COUNTER,
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR_WORD,
    input wire logic PC_LOAD,
    input wire logic [15:0] PC_LOAD_VALUE,
    // datapath status
    input wire logic INT_PENDING,
    input wire logic INT_ENABLED,
    // decoded instruction
    output logic [11:0] IR_DATA,
    output logic ILLEGAL_MODE,
    // microcode control
    output logic [8*MW_BYTES-1:0] MICROWORD,
    output logic [UADDR_W-1:0] MICRO_ADDR,
    output logic [3:0] SRC_EN,
    output logic [2:0] LOOP_COUNT,
    // control store load port
    input wire logic UCODE_WR_EN,
    input wire logic [3:0] UCODE_WR_SEL,
    input wire logic [9:0] UCODE_WR_ADDR,
    input wire logic [7:0] UCODE_WR_DATA
);

    useq_pkg::seq_state_e state_q;
    useq_pkg::ir_s ir_q;
    useq_pkg::seq_ctl_s ctl;
    useq_pkg::step_ctl_s step;
    logic [15:0] pc_q;
    logic [8*MW_BYTES-1:0] mw_q;
    logic [8*MW_BYTES-1:0] mw_d;
    logic [UADDR_W-1:0] upc_q;
    logic [UADDR_W-1:0] next_addr;
    logic [7:0] exec_q;
    logic [7:0] disp_val;
    logic [7:0] exec_val;
    logic [7:0] next_b_val;
    logic [7:0] next_sel;
    logic [2:0] loop_q;
    logic [2:0] src_mode_c;
    logic [2:0] dst_mode_c;
    logic [9:0] disp_index;
    logic [3:0] src_en;
    logic [1:0] src_sel;
    logic illegal_c;
    logic illegal_q;
    logic pref_q;
    logic fetched_any_q;
    logic ir_load;
    logic dispatch_now;
    logic run_step;
    logic cond_true;
    logic page;

    // writable control stores; not reset, software loads them first
    logic [7:0] ctl_store [MW_BYTES][STORE_DEPTH];
    logic [7:0] next_b_store [STORE_DEPTH];
    logic [7:0] disp_store [DISP_DEPTH];
    logic [7:0] exec_store [DISP_DEPTH];

    // a source index to its driver enable
    function automatic logic [3:0] src_onehot(input logic [1:0] s);
        return 4'h1 << s;
    endfunction

    mode_predecode u_predecode
    (
        .src_field (INSTR_WORD[`INSTR_SRC]),
        .dst_field (INSTR_WORD[`INSTR_DST]),
        .src_mode (src_mode_c),
        .dst_mode (dst_mode_c),
        .illegal (illegal_c)
    );

    assign ctl = mw_q[`MW_SEQ];
    assign step = mw_q[`MW_STEP];

    // fetch handshake; a prefetch is not repeated once one is held
    assign FETCH_REQ = (state_q == useq_pkg::ST_FETCH) ||
        ((state_q == useq_pkg::ST_RUN) && step.fetch && !pref_q);
    assign ir_load = FETCH_REQ && INSTR_VALID;
    assign dispatch_now = (state_q == useq_pkg::ST_DISPATCH) ||
        ((state_q == useq_pkg::ST_RUN) && ctl.end_instr && pref_q); // RULE_04
    assign run_step = (state_q == useq_pkg::ST_RUN) && !ctl.end_instr;

    assign disp_index = {ir_q.opcode, ir_q.src_mode, ir_q.dst_mode}; // RULE_07
    assign disp_val = disp_store[disp_index]; // RULE_08
    assign exec_val = exec_store[disp_index];
    assign next_b_val = next_b_store[upc_q]; // RULE_13

    always_comb
    begin
        case (ctl.cond) // RULE_11
            `COND_ALWAYS: cond_true = 1'b1; // RULE_12
            `COND_LOOP_ZERO: cond_true = (loop_q == `LOOP_ZERO); // RULE_12
            `COND_INT_TAKE: cond_true = INT_PENDING && INT_ENABLED; // RULE_15
            `COND_INT_ENABLED: cond_true = INT_ENABLED; // RULE_12
            default: cond_true = 1'b0;
        endcase
    end

    always_comb
    begin
        src_sel = cond_true ? ctl.src_true : ctl.src_false; // RULE_15
        if (dispatch_now)
            src_en = src_onehot(`SRC_DISPATCH); // RULE_02
        else if (run_step)
            src_en = src_onehot(src_sel); // RULE_11
        else
            src_en = 4'h0;
    end

    // and-or of the four enabled drivers, one enable at most
    always_comb
    begin
        next_sel = ({8{src_en[0]}} & disp_val) | ({8{src_en[1]}} & exec_q) |
            ({8{src_en[2]}} & mw_q[`MW_NEXT_A]) | ({8{src_en[3]}} & next_b_val); // RULE_10
        page = (src_en[2] || src_en[3]) && step.page;
        next_addr = {page, next_sel};
    end

    genvar b;
    generate
        for (b = 0; b < MW_BYTES; b++)
        begin : g_lane
            assign mw_d[8*b +: 8] = ctl_store[b][next_addr]; // RULE_13
            always_ff @(posedge CLK_SYS)
            begin
                if (UCODE_WR_EN && (UCODE_WR_SEL == 4'(b)))
                    ctl_store[b][UCODE_WR_ADDR[UADDR_W-1:0]] <= UCODE_WR_DATA;
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS)
    begin
        if (UCODE_WR_EN && (UCODE_WR_SEL == `WSEL_NEXT_B))
            next_b_store[UCODE_WR_ADDR[UADDR_W-1:0]] <= UCODE_WR_DATA;
        if (UCODE_WR_EN && (UCODE_WR_SEL == `WSEL_DISP))
            disp_store[UCODE_WR_ADDR] <= UCODE_WR_DATA;
        if (UCODE_WR_EN && (UCODE_WR_SEL == `WSEL_EXEC))
            exec_store[UCODE_WR_ADDR] <= UCODE_WR_DATA;
    end

    // sequencing state
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
            state_q <= useq_pkg::ST_FETCH; // RULE_01
        else
            case (state_q)
                useq_pkg::ST_FETCH:
                    if (ir_load)
                        state_q <= useq_pkg::ST_DISPATCH;
                useq_pkg::ST_DISPATCH:
                    state_q <= useq_pkg::ST_RUN;
                useq_pkg::ST_RUN:
                    if (ctl.end_instr && !pref_q)
                        state_q <= ir_load ? useq_pkg::ST_DISPATCH : useq_pkg::ST_FETCH; // RULE_04
                default:
                    state_q <= useq_pkg::ST_FETCH;
            endcase
    end

    // pipeline register; cleared to a no-op word while waiting on a fetch
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            mw_q <= '0;
            upc_q <= '0;
        end
        else if (|src_en)
        begin
            mw_q <= mw_d; // RULE_03
            upc_q <= next_addr; // RULE_03
        end
        else
            mw_q <= '0;
    end

    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
            pc_q <= `PC_RESET; // RULE_01
        else if (PC_LOAD)
            pc_q <= PC_LOAD_VALUE;
        else if (ir_load)
            pc_q <= 16'(pc_q + `PC_STEP);
    end

    // predecoded fields go into the holding register
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            ir_q <= '0;
            illegal_q <= 1'b0;
        end
        else if (ir_load)
        begin
            ir_q <= {INSTR_WORD[`INSTR_OPC], src_mode_c, dst_mode_c,
                INSTR_WORD[`INSTR_DATA]}; // RULE_05
            illegal_q <= illegal_c; // RULE_06
        end
    end

    // prefetch flag; a load during the ending word dispatches directly
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
            pref_q <= 1'b0;
        else if (ir_load && (state_q == useq_pkg::ST_RUN) && !ctl.end_instr)
            pref_q <= 1'b1; // RULE_04
        else if (dispatch_now)
            pref_q <= 1'b0;
    end

    // prefetch overwrites the ir, so execute start is held here
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
            exec_q <= 8'h00;
        else if (dispatch_now)
            exec_q <= exec_val; // RULE_09
    end

    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
            loop_q <= `LOOP_ZERO;
        else if (step.loop_load)
            loop_q <= ir_q.data[`DATA_SRC_REG]; // RULE_14
        else if (step.loop_step)
            loop_q <= loop_q - `LOOP_STEP; // RULE_14
    end

    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
            fetched_any_q <= 1'b0;
        else if (ir_load)
            fetched_any_q <= 1'b1;
    end

    assign PROGRAM_COUNTER = pc_q;
    assign IR_DATA = ir_q.data;
    assign ILLEGAL_MODE = illegal_q;
    assign MICROWORD = mw_q;
    assign MICRO_ADDR = upc_q;
    assign SRC_EN = src_en;
    assign LOOP_COUNT = loop_q;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    AST_PC_FIRST: assert property (FETCH_REQ && !fetched_any_q |-> pc_q == `PC_RESET) // RULE_01
        else $error("first fetch not at address zero");
    AST_FETCH_DISPATCH: assert property ( // RULE_02
        (state_q == useq_pkg::ST_FETCH) && ir_load |=> dispatch_now ##1 state_q == useq_pkg::ST_RUN)
        else $error("fetched instruction not dispatched");
    AST_DISPATCH_TARGET: assert property (dispatch_now |=> upc_q == {1'b0, $past(disp_val)}) // RULE_08
        else $error("dispatch address not from first table");
    AST_STEP_LOAD: assert property (run_step |=> upc_q == $past(next_addr)) // RULE_03
        else $error("pipeline did not advance");
    AST_END_REFETCH: assert property ( // RULE_04
        (state_q == useq_pkg::ST_RUN) && ctl.end_instr && !pref_q && !ir_load
        |=> FETCH_REQ && (mw_q == '0))
        else $error("no fetch after instruction end");
    AST_PREFETCH_REUSE: assert property ( // RULE_04
        (state_q == useq_pkg::ST_RUN) && ctl.end_instr && pref_q |-> dispatch_now && !FETCH_REQ)
        else $error("prefetched instruction refetched");
    AST_ILLEGAL_FLAG: assert property (ILLEGAL_MODE == ((ir_q.src_mode == `MODE_ILLEGAL) || // RULE_06
        (ir_q.dst_mode == `MODE_ILLEGAL)))
        else $error("illegal flag disagrees with modes");
    AST_EXEC_HELD: assert property (!dispatch_now |=> $stable(exec_q)) // RULE_09
        else $error("held execute address changed");
    AST_ONE_SOURCE: assert property ($onehot0(src_en) && ((dispatch_now || run_step) == (|src_en))) // RULE_10
        else $error("next address source not unique");
    AST_INT_GATE: assert property (run_step && (ctl.cond == `COND_INT_TAKE) && // RULE_15
        !(INT_PENDING && INT_ENABLED) |-> src_en == src_onehot(ctl.src_false))
        else $error("interrupt branch taken without both bits");
    AST_LOOP_STEP: assert property (step.loop_step && !step.loop_load |=> // RULE_14
        loop_q == 3'($past(loop_q) - `LOOP_STEP))
        else $error("loop counter did not step");

    COV_PREFETCH_DISPATCH: cover property ((state_q == useq_pkg::ST_RUN) && dispatch_now);
    COV_INT_BRANCH: cover property (run_step && (ctl.cond == `COND_INT_TAKE) && cond_true);
    COV_LOOP_ZERO: cover property (run_step && (ctl.cond == `COND_LOOP_ZERO) && cond_true);
    COV_ILLEGAL: cover property (ir_load && illegal_c);

endmodule // microprogram_sequencer
`default_nettype wire

/* core/mode_predecode.sv */
// operand field predecoder: 6-bit fields to 3-bit mode codes
`timescale 1ns/10ps
`default_nettype none
`include "useq_params.svh"

module mode_predecode
(
    // raw operand fields
    input wire logic [5:0] src_field,
    input wire logic [5:0] dst_field,
    // mode codes
    output logic [2:0] src_mode,
    output logic [2:0] dst_mode,
    output logic illegal
);

    // register-free modes other than short immediate must name register zero, else illegal
    function automatic logic [2:0] predecode_mode(input logic [5:0] fld);
        logic [2:0] code;
        code = `MODE_ILLEGAL;
        case (fld[`FLD_KIND])
            `KIND_REG: code = `MODE_REG;
            `KIND_REG_IND: code = `MODE_REG_IND;
            `KIND_REG_IDX: code = `MODE_REG_IDX;
            `KIND_ABS: code = (fld[`FLD_REG] == `REG_NONE) ? `MODE_ABS : `MODE_ILLEGAL;
            `KIND_SP_POSTINC:
                code = (fld[`FLD_REG] == `REG_NONE) ? `MODE_SP_POSTINC : `MODE_ILLEGAL;
            `KIND_SP_PREDEC:
                code = (fld[`FLD_REG] == `REG_NONE) ? `MODE_SP_PREDEC : `MODE_ILLEGAL;
            `KIND_SHORT_IMM: code = `MODE_SHORT_IMM;
            default: code = `MODE_ILLEGAL;
        endcase
        return code;
    endfunction

    always_comb
    begin
        src_mode = predecode_mode(src_field); // RULE_05
        dst_mode = predecode_mode(dst_field); // RULE_05
        illegal = (src_mode == `MODE_ILLEGAL) || (dst_mode == `MODE_ILLEGAL); // RULE_06
    end

endmodule // mode_predecode
`default_nettype wire

/* core/useq_params.svh */
// constants for the microprogram sequencer
`ifndef USEQ_PARAMS_SVH
`define USEQ_PARAMS_SVH

// addressing-mode codes
`define MODE_ABS 3'h0
`define MODE_SP_POSTINC 3'h1
`define MODE_SP_PREDEC 3'h2
`define MODE_SHORT_IMM 3'h3
`define MODE_REG 3'h4
`define MODE_REG_IND 3'h5
`define MODE_REG_IDX 3'h6
`define MODE_ILLEGAL 3'h7

// raw operand field layout
`define FLD_KIND 5:3
`define FLD_REG 2:0
`define KIND_REG 3'h0
`define KIND_REG_IND 3'h1
`define KIND_REG_IDX 3'h2
`define KIND_ABS 3'h4
`define KIND_SP_POSTINC 3'h5
`define KIND_SP_PREDEC 3'h6
`define KIND_SHORT_IMM 3'h7
`define REG_NONE 3'h0

// instruction word layout
`define INSTR_OPC 15:12
`define INSTR_SRC 11:6
`define INSTR_DST 5:0
`define INSTR_DATA 11:0
`define DATA_SRC_REG 8:6

// microbranch conditions
`define COND_ALWAYS 3'h0
`define COND_LOOP_ZERO 3'h1
`define COND_INT_TAKE 3'h2
`define COND_INT_ENABLED 3'h3

// next-address sources
`define SRC_DISPATCH 2'h0
`define SRC_EXEC 2'h1
`define SRC_NEXT_A 2'h2
`define SRC_NEXT_B 2'h3

// microword byte lanes
`define MW_NEXT_A 7:0
`define MW_SEQ 15:8
`define MW_STEP 23:16

// store select codes of the load port
`define WSEL_NEXT_B 4'h8
`define WSEL_DISP 4'h9
`define WSEL_EXEC 4'hA

`define PC_RESET 16'h0000
`define PC_STEP 16'h0001
`define LOOP_ZERO 3'h0
`define LOOP_STEP 3'h1

`endif

/* core/useq_pkg.sv */
// types shared by the microprogram sequencer files
package useq_pkg;

    typedef enum logic [1:0] {ST_FETCH, ST_DISPATCH, ST_RUN} seq_state_e;

    // predecoded instruction holding register
    typedef struct packed {
        logic [3:0] opcode;
        logic [2:0] src_mode;
        logic [2:0] dst_mode;
        logic [11:0] data;
    } ir_s;

    // microword byte 1: branch control
    typedef struct packed {
        logic end_instr;
        logic [1:0] src_false;
        logic [1:0] src_true;
        logic [2:0] cond;
    } seq_ctl_s;

    // microword byte 2: fetch and loop control
    typedef struct packed {
        logic [3:0] spare;
        logic page;
        logic loop_step;
        logic loop_load;
        logic fetch;
    } step_ctl_s;

endpackage

/* sim/fetch_partner.sv */
// instruction memory model answering the sequencer's fetch requests
`timescale 1ns/10ps
`default_nettype none

module fetch_partner
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fetch handshake
    input wire logic fetch_req,
    input wire logic [15:0] pc,
    output logic instr_valid,
    output logic [15:0] instr_word,
    // words the bench lets the model hand over, and words taken so far
    input wire logic [7:0] limit,
    output logic [7:0] taken
);
    logic [15:0] mem [0:255];
    logic [1:0] delay_q;
    logic [7:0] lfsr_q;

    // an idle word bus shows the inverse of the last word, never the stale one
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            instr_valid <= 1'b0;
            instr_word <= 16'hFFFF;
            taken <= 8'h00;
            delay_q <= 2'h0;
            lfsr_q <= 8'h5B;
        end
        else if (instr_valid && fetch_req)
        begin
            taken <= taken + 8'h01;
            instr_valid <= 1'b0;
            instr_word <= ~instr_word;
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
            delay_q <= lfsr_q[1:0];
        end
        else if (!instr_valid && fetch_req && taken != limit)
        begin
            // random wait of 0 to 3 cycles, so both prompt and slow answers occur
            if (delay_q == 2'h0)
            begin
                instr_valid <= 1'b1;
                instr_word <= mem[pc[7:0]];
            end
            else
                delay_q <= delay_q - 2'h1;
        end
    end
endmodule // fetch_partner

`default_nettype wire

/* sim/microprogram_sequencer_bench.sv */
// self-checking bench of the microprogram sequencer
`timescale 1ns/10ps
`default_nettype none

module microprogram_sequencer_bench;
    logic CLK_SYS, RESET, FETCH_REQ, INSTR_VALID, PC_LOAD, INT_PENDING, INT_ENABLED;
    logic ILLEGAL_MODE, UCODE_WR_EN;
    logic [15:0] PROGRAM_COUNTER, INSTR_WORD, PC_LOAD_VALUE, w;
    logic [11:0] IR_DATA;
    logic [63:0] MICROWORD;
    logic [8:0] MICRO_ADDR;
    logic [3:0] SRC_EN, UCODE_WR_SEL;
    logic [2:0] LOOP_COUNT, s, d, r;
    logic [9:0] UCODE_WR_ADDR, mon_e;
    logic [7:0] UCODE_WR_DATA, limit, taken;
    logic [7:0] cs [0:8][0:511];
    logic [9:0] exp_q [$];
    logic [31:0] seed;
    int errors, checked;

    microprogram_sequencer i_dut (.CLK_SYS(CLK_SYS), .RESET(RESET), .FETCH_REQ(FETCH_REQ),
        .PROGRAM_COUNTER(PROGRAM_COUNTER), .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD),
        .PC_LOAD(PC_LOAD), .PC_LOAD_VALUE(PC_LOAD_VALUE), .INT_PENDING(INT_PENDING),
        .INT_ENABLED(INT_ENABLED), .IR_DATA(IR_DATA), .ILLEGAL_MODE(ILLEGAL_MODE),
        .MICROWORD(MICROWORD), .MICRO_ADDR(MICRO_ADDR), .SRC_EN(SRC_EN), .LOOP_COUNT(LOOP_COUNT),
        .UCODE_WR_EN(UCODE_WR_EN), .UCODE_WR_SEL(UCODE_WR_SEL), .UCODE_WR_ADDR(UCODE_WR_ADDR),
        .UCODE_WR_DATA(UCODE_WR_DATA));

    fetch_partner i_mem (.clk(CLK_SYS), .rst(RESET), .fetch_req(FETCH_REQ),
        .pc(PROGRAM_COUNTER), .instr_valid(INSTR_VALID), .instr_word(INSTR_WORD),
        .limit(limit), .taken(taken));

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    function automatic logic [2:0] mode_of(input logic [5:0] f);
        case (f[5:3])
            3'h0: return 3'h4;
            3'h1: return 3'h5;
            3'h2: return 3'h6;
            3'h3: return 3'h7;
            3'h7: return 3'h3;
            default: return (f[2:0] == 3'h0) ? f[5:3] - 3'h4 : 3'h7;
        endcase
    endfunction

    function automatic logic [63:0] word_of(input logic [8:0] a);
        for (int k = 0; k < 8; k++)
            word_of[8*k +: 8] = cs[k][a];
    endfunction

    task automatic check_addr(input string what, input logic [8:0] e, input logic [8:0] v);
        checked++;
        if (v !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, v);
        end
    endtask

    task automatic check_word(input string what, input logic [63:0] e, input logic [63:0] v);
        checked++;
        if (v !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, v);
        end
    endtask

    task automatic check_flag(input string what, input logic e, input logic v);
        checked++;
        if (v !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, v);
        end
    endtask

    task automatic wr(input logic [3:0] sel, input logic [9:0] a, input logic [7:0] dat);
        UCODE_WR_EN <= 1'b1;
        UCODE_WR_SEL <= sel;
        UCODE_WR_ADDR <= a;
        UCODE_WR_DATA <= dat;
        @(posedge CLK_SYS);
    endtask

    task automatic setw(input logic [8:0] a, input logic [7:0] na, input logic [7:0] sq,
        input logic [7:0] st);
        cs[0][a] = na;
        cs[1][a] = sq;
        cs[2][a] = st;
    endtask

    // lets the model hand over n words, then waits for every noted word to appear
    task automatic run_group(input logic [7:0] n);
        int t;
        t = 0;
        limit <= limit + n;
        while (exp_q.size() != 0 && t < 5000)
        begin
            @(posedge CLK_SYS);
            t++;
        end
        if (t == 5000)
        begin
            errors++;
            $display("CHECK FAILED pending words expected 0 seen %0d", exp_q.size());
        end
        repeat (4) @(posedge CLK_SYS);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        CLK_SYS = 1'b0;
        forever #4 CLK_SYS = ~CLK_SYS;
    end

    // every non-zero pipeline word is one result; a cleared word means waiting for fetch
    // sampled mid-cycle, so registered outputs have settled after their launching edge
    always @(negedge CLK_SYS)
    begin
        if (!RESET)
            check_flag("source enables", 1'b1, $onehot0(SRC_EN));
        if (!RESET && MICROWORD !== 64'h0000_0000_0000_0000)
        begin
            if (exp_q.size() == 0)
                check_flag("extra microword", 1'b0, 1'b1);
            else
            begin
                mon_e = exp_q.pop_front();
                check_addr("micro address", mon_e[8:0], MICRO_ADDR);
                check_word("microword", word_of(mon_e[8:0]), MICROWORD);
                check_flag("illegal mode", mon_e[9], ILLEGAL_MODE);
            end
        end
    end

    initial
    begin
        #(8 * 40000);
        errors++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        give_verdict();
    end

    initial
    begin
        RESET = 1'b1;
        PC_LOAD = 1'b0;
        PC_LOAD_VALUE = 16'h0000;
        INT_PENDING = 1'b0;
        INT_ENABLED = 1'b0;
        UCODE_WR_EN = 1'b0;
        UCODE_WR_SEL = 4'h0;
        UCODE_WR_ADDR = 10'h000;
        UCODE_WR_DATA = 8'h00;
        limit = 8'h00;
        errors = 0;
        checked = 0;
        seed = 32'h0001_5D57;
        // default words end the instruction; the datapath bytes mark their address
        for (int a = 0; a < 512; a++)
        begin
            for (int k = 3; k < 8; k++)
                cs[k][a] = 8'(a) ^ 8'(k * 37) ^ {a[8], 7'h00};
            cs[0][a] = 8'(a) ^ 8'h3C;
            cs[1][a] = 8'h80;
            cs[2][a] = 8'h00;
            cs[8][a] = ~8'(a);
        end
        setw(9'h092, 8'h10, 8'h10, 8'h0A);
        setw(9'h110, 8'h10, 8'h59, 8'h0C);
        setw(9'h120, 8'h40, 8'h5A, 8'h09);
        setw(9'h0B2, 8'h40, 8'h5B, 8'h08);
        setw(9'h140, 8'h50, 8'h10, 8'h09);
        // fetch bits on three words in a row let a prefetch land before the ending word
        setw(9'h150, 8'h00, 8'h08, 8'h01);
        cs[8][9'h110] = 8'h20;
        cs[8][9'h120] = 8'h30;
        cs[8][9'h0B2] = 8'h30;
        repeat (3) @(posedge CLK_SYS);
        RESET <= 1'b0;
        @(posedge CLK_SYS);
        #1;
        check_word("program counter", 64'h0000_0000_0000_0000, 64'(PROGRAM_COUNTER));
        check_flag("fetch request", 1'b1, FETCH_REQ);
        @(posedge CLK_SYS);
        for (int k = 0; k < 9; k++)
            for (int a = 0; a < 512; a++)
                wr(4'(k), 10'(a), cs[k][a]);
        for (int i = 0; i < 1024; i++)
            wr(4'h9, 10'(i), {i[5:0], i[7:6]});
        for (int i = 0; i < 1024; i++)
            wr(4'hA, 10'(i), 8'(i) ^ 8'h5A);
        UCODE_WR_EN <= 1'b0;
        $display("test reset_and_load done");
        // every source and destination field, starting at address zero
        for (int i = 0; i < 128; i++)
        begin
            w = (i < 64) ? {i[3:2], 2'b01, 6'(i), 6'h00} : {i[3:2], 2'b01, 6'h00, 6'(i)};
            i_mem.mem[i] = w;
            s = mode_of(w[11:6]);
            d = mode_of(w[5:0]);
            exp_q.push_back({(s == 3'h7 || d == 3'h7), 1'b0, s, d, 2'b01});
        end
        // random interrupt levels; an always-taken branch must ignore them
        seed = xorshift(seed);
        INT_PENDING <= seed[9];
        INT_ENABLED <= seed[10];
        run_group(8'h80);
        check_word("program counter", 64'h0000_0000_0000_0080, 64'(PROGRAM_COUNTER));
        check_word("held data", {52'h0, w[11:0]}, 64'(IR_DATA));
        $display("test predecode done");
        seed = xorshift(seed);
        PC_LOAD_VALUE <= {seed[15:8], 8'hC8};
        PC_LOAD <= 1'b1;
        @(posedge CLK_SYS);
        PC_LOAD <= 1'b0;
        @(posedge CLK_SYS);
        #1;
        check_word("loaded counter", {48'h0, seed[15:8], 8'hC8}, 64'(PROGRAM_COUNTER));
        @(posedge CLK_SYS);
        // loop, interrupt branches, held execute address and prefetch per interrupt state
        for (int c = 0; c < 4; c++)
        begin
            seed = xorshift(seed);
            r = seed[2:0];
            INT_PENDING <= c[1];
            INT_ENABLED <= c[0];
            i_mem.mem[200 + 2 * c] = {4'hE, 3'h0, r, 6'h00};
            i_mem.mem[201 + 2 * c] = {4'hE, 3'h1, seed[5:3], 6'h00};
            exp_q.push_back(10'h092);
            for (int j = 0; j <= r; j++)
                exp_q.push_back(10'h110);
            exp_q.push_back(10'h120);
            if (c == 3)
                exp_q.push_back(10'h130);
            else
                exp_q = {exp_q, 10'h140, 10'h150, 10'h0FE};
            exp_q.push_back(10'h0B2);
            if (c[0])
                exp_q.push_back(10'h130);
            else
                exp_q = {exp_q, 10'h140, 10'h150, 10'h0F6};
            run_group(8'h02);
            // r+1 steps down from r leave the counter wrapped to all ones
            check_word("loop count", 64'h0000_0000_0000_0007, 64'(LOOP_COUNT));
            $display("test sequencing %0d done", c);
        end
        give_verdict();
    end
endmodule // microprogram_sequencer_bench

`default_nettype wire
